// file: verilog/trap_rec_pkg.sv
// Package of constants and types for the trap cause and value recorder
package trap_rec_pkg;
    localparam int XW = 32;
    localparam int AW = 4;
    localparam int CODE_W = 6;

    // Register byte offsets on the bus
    localparam logic [AW-1:0] OFF_CAUSE = 4'h0;
    localparam logic [AW-1:0] OFF_VALUE = 4'h4;
    localparam logic [AW-1:0] OFF_EPC = 4'h8;
    localparam logic [AW-1:0] OFF_CTRL = 4'hc;

    // Reset values
    localparam logic [XW-1:0] CAUSE_RST = 32'h0000_0000;
    localparam logic [XW-1:0] VALUE_RST = 32'h0000_0000;
    localparam logic [XW-1:0] EPC_RST = 32'h0000_0000;
    localparam logic [XW-1:0] UNMAPPED_RDATA = 32'h0000_0000;
    localparam int CTRL_INSN_BIT = 0;
    localparam int CTRL_W = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 1'h1;

    // Cause interrupt flag bit position
    localparam int CAUSE_FLAG_BIT = XW - 1;

    // Interrupt codes
    localparam logic [CODE_W-1:0] IRQ_SW_U = 6'h00;
    localparam logic [CODE_W-1:0] IRQ_SW_S = 6'h01;
    localparam logic [CODE_W-1:0] IRQ_SW_M = 6'h03;
    localparam logic [CODE_W-1:0] IRQ_TM_U = 6'h04;
    localparam logic [CODE_W-1:0] IRQ_TM_S = 6'h05;
    localparam logic [CODE_W-1:0] IRQ_TM_M = 6'h07;
    localparam logic [CODE_W-1:0] IRQ_EX_U = 6'h08;
    localparam logic [CODE_W-1:0] IRQ_EX_S = 6'h09;
    localparam logic [CODE_W-1:0] IRQ_EX_M = 6'h0b;
    localparam logic [CODE_W-1:0] IRQ_PLAT_MIN = 6'h10;

    // Exception codes
    localparam logic [CODE_W-1:0] EXC_FETCH_MISAL = 6'h00;
    localparam logic [CODE_W-1:0] EXC_FETCH_ACC = 6'h01;
    localparam logic [CODE_W-1:0] EXC_ILLEGAL = 6'h02;
    localparam logic [CODE_W-1:0] EXC_BREAK = 6'h03;
    localparam logic [CODE_W-1:0] EXC_LOAD_MISAL = 6'h04;
    localparam logic [CODE_W-1:0] EXC_LOAD_ACC = 6'h05;
    localparam logic [CODE_W-1:0] EXC_STORE_MISAL = 6'h06;
    localparam logic [CODE_W-1:0] EXC_STORE_ACC = 6'h07;
    localparam logic [CODE_W-1:0] EXC_ECALL_U = 6'h08;
    localparam logic [CODE_W-1:0] EXC_ECALL_S = 6'h09;
    localparam logic [CODE_W-1:0] EXC_ECALL_M = 6'h0b;
    localparam logic [CODE_W-1:0] EXC_FETCH_PAGE = 6'h0c;
    localparam logic [CODE_W-1:0] EXC_LOAD_PAGE = 6'h0d;
    localparam logic [CODE_W-1:0] EXC_STORE_PAGE = 6'h0f;
    localparam logic [CODE_W-1:0] EXC_CUST_A_LO = 6'h18;
    localparam logic [CODE_W-1:0] EXC_CUST_A_HI = 6'h1f;
    localparam logic [CODE_W-1:0] EXC_CUST_B_LO = 6'h30;
    localparam logic [CODE_W-1:0] EXC_CUST_B_HI = 6'h3f;

    // Exception request vector bit positions, highest priority first
    localparam int NEXC = 15;
    localparam int X_FETCH_BRK = 14;
    localparam int X_FETCH_PAGE = 13;
    localparam int X_FETCH_ACC = 12;
    localparam int X_ILLEGAL = 11;
    localparam int X_FETCH_MISAL = 10;
    localparam int X_ECALL = 9;
    localparam int X_ENV_BRK = 8;
    localparam int X_DATA_BRK = 7;
    localparam int X_STORE_MISAL = 6;
    localparam int X_LOAD_MISAL = 5;
    localparam int X_STORE_PAGE = 4;
    localparam int X_LOAD_PAGE = 3;
    localparam int X_STORE_ACC = 2;
    localparam int X_LOAD_ACC = 1;
    localparam int X_CUSTOM = 0;

    // What the value register receives
    typedef enum logic [2:0] {
        VAL_ZERO = 3'b001,
        VAL_ADDR = 3'b010,
        VAL_INSN = 3'b100
    } val_src_t;

    // Privilege of the ecall origin
    typedef enum logic [1:0] {
        PRIV_U = 2'h0,
        PRIV_S = 2'h1,
        PRIV_M = 2'h3
    } priv_t;
endpackage

// file: verilog/trap_sel_if.sv
// Interface between the recorder and its priority selector
`timescale 1ns/1ns
`default_nettype none
interface trap_sel_if;
    import trap_rec_pkg::*;
    logic [NEXC-1:0] exc_req;
    logic [CODE_W-1:0] cust_code;
    priv_t ecall_priv;
    logic any;
    logic [CODE_W-1:0] code;
    val_src_t src;
    logic data_side;

    modport requester(output exc_req, output cust_code, output ecall_priv,
        input any, input code, input src, input data_side);
    modport selector(input exc_req, input cust_code, input ecall_priv,
        output any, output code, output src, output data_side);
endinterface
`default_nettype wire

// file: verilog/trap_prio_sel.sv
// Priority selector for simultaneous synchronous exceptions
`timescale 1ns/1ns
`default_nettype none
module trap_prio_sel
    import trap_rec_pkg::*;
(
    trap_sel_if.selector sel
);
    function automatic logic [CODE_W-1:0] ecall_code(input priv_t p);
        unique case (p)
            PRIV_U: ecall_code = EXC_ECALL_U;
            PRIV_S: ecall_code = EXC_ECALL_S;
            default: ecall_code = EXC_ECALL_M;
        endcase
    endfunction

    // Custom codes outside the two custom windows are never emitted
    function automatic logic cust_ok(input logic [CODE_W-1:0] c);
        cust_ok = (c >= EXC_CUST_A_LO && c <= EXC_CUST_A_HI) ||
            (c >= EXC_CUST_B_LO && c <= EXC_CUST_B_HI);
    endfunction

    logic [NEXC-1:0] req;
    assign req = {sel.exc_req[NEXC-1:1], sel.exc_req[X_CUSTOM] & cust_ok(sel.cust_code)};
    assign sel.any = |req;

    // ---------------------------------------------------------------
    // Priority chain
    // ---------------------------------------------------------------
    // fixed ordering, breakpoints share code 3
    always_comb begin
        sel.code = EXC_FETCH_MISAL;
        sel.src = VAL_ZERO;
        sel.data_side = 1'b0;
        if (req[X_FETCH_BRK]) begin
            sel.code = EXC_BREAK;
            sel.src = VAL_ADDR;
        end else if (req[X_FETCH_PAGE]) begin
            sel.code = EXC_FETCH_PAGE;
            sel.src = VAL_ADDR;
        end else if (req[X_FETCH_ACC]) begin
            sel.code = EXC_FETCH_ACC;
            sel.src = VAL_ADDR;
        end else if (req[X_ILLEGAL]) begin
            sel.code = EXC_ILLEGAL;
            sel.src = VAL_INSN;
        end else if (req[X_FETCH_MISAL]) begin
            sel.code = EXC_FETCH_MISAL;
            sel.src = VAL_ADDR;
        end else if (req[X_ECALL]) begin
            sel.code = ecall_code(sel.ecall_priv);
        end else if (req[X_ENV_BRK]) begin
            sel.code = EXC_BREAK;
        end else if (req[X_DATA_BRK]) begin
            sel.code = EXC_BREAK;
            sel.src = VAL_ADDR;
            sel.data_side = 1'b1;
        end else if (req[X_STORE_MISAL]) begin
            sel.code = EXC_STORE_MISAL;
            sel.src = VAL_ADDR;
            sel.data_side = 1'b1;
        end else if (req[X_LOAD_MISAL]) begin
            sel.code = EXC_LOAD_MISAL;
            sel.src = VAL_ADDR;
            sel.data_side = 1'b1;
        end else if (req[X_STORE_PAGE]) begin
            sel.code = EXC_STORE_PAGE;
            sel.src = VAL_ADDR;
            sel.data_side = 1'b1;
        end else if (req[X_LOAD_PAGE]) begin
            sel.code = EXC_LOAD_PAGE;
            sel.src = VAL_ADDR;
            sel.data_side = 1'b1;
        end else if (req[X_STORE_ACC]) begin
            sel.code = EXC_STORE_ACC;
            sel.src = VAL_ADDR;
            sel.data_side = 1'b1;
        end else if (req[X_LOAD_ACC]) begin
            sel.code = EXC_LOAD_ACC;
            sel.src = VAL_ADDR;
            sel.data_side = 1'b1;
        end else if (req[X_CUSTOM]) begin
            // custom window codes only, lowest priority here
            sel.code = sel.cust_code;
        end
    end
endmodule
`default_nettype wire

// file: verilog/trap_cause_value_recorder.sv
// Trap cause, trap value and exception pc registers with an Avalon-MM slave
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module trap_cause_value_recorder
    import trap_rec_pkg::*;
#(
    parameter int MAX_INSTR_LENGTH = 32
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // Trap report from the pipeline, held high while TRAP_STALL_OUT is raised
    input wire logic TRAP_IN,
    input wire logic TRAP_IRQ_IN,
    input wire logic [CODE_W-1:0] IRQ_CODE_IN,
    input wire logic [NEXC-1:0] EXC_REQ_IN,
    input wire logic [CODE_W-1:0] CUST_CODE_IN,
    input wire logic [1:0] ECALL_PRIV_IN,
    input wire logic [XW-1:0] TRAP_PC_IN,
    input wire logic [XW-1:0] FETCH_ADDR_IN,
    input wire logic [XW-1:0] DATA_ADDR_IN,
    input wire logic [XW-1:0] INSN_BITS_IN,
    input wire logic [7:0] INSN_LEN_IN,
    input wire logic INSN_FULL_IN,
    // Avalon-MM slave
    input wire logic [AW-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [XW-1:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [XW-1:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output logic [XW-1:0] CAUSE_OUT,
    output logic [XW-1:0] VALUE_OUT,
    output logic [XW-1:0] EPC_OUT,
    output logic TRAP_STALL_OUT,
    output logic TRAP_DONE_OUT
);
    // Instruction capture width is the smaller of register width and max length
    localparam int CAP_W = (XW < MAX_INSTR_LENGTH) ? XW : MAX_INSTR_LENGTH;

    trap_sel_if sel ();

    // All checks below run on the core clock and rest while reset is high
    default clocking cb_core @(posedge REF_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    logic [XW-1:0] cause_r;
    logic [XW-1:0] value_r;
    logic [XW-1:0] epc_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [XW-1:0] rdata_r;
    logic ack_r;
    logic done_r;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [XW-1:0] merge_be(input logic [XW-1:0] old, input logic [XW-1:0] wd,
        input logic [3:0] be);
        logic [XW-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge_be = r;
    endfunction

    // Interrupt codes the block supports; reserved ones written by software are not retained
    function automatic logic irq_ok(input logic [CODE_W-1:0] c);
        irq_ok = (c == IRQ_SW_U) || (c == IRQ_SW_S) || (c == IRQ_SW_M) ||
            (c == IRQ_TM_U) || (c == IRQ_TM_S) || (c == IRQ_TM_M) ||
            (c == IRQ_EX_U) || (c == IRQ_EX_S) || (c == IRQ_EX_M) ||
            (c >= IRQ_PLAT_MIN);
    endfunction

    function automatic logic exc_ok(input logic [CODE_W-1:0] c);
        exc_ok = (c <= EXC_ECALL_S) || (c == EXC_ECALL_M) || (c == EXC_FETCH_PAGE) ||
            (c == EXC_LOAD_PAGE) || (c == EXC_STORE_PAGE) ||
            (c >= EXC_CUST_A_LO && c <= EXC_CUST_A_HI) || (c >= EXC_CUST_B_LO);
    endfunction

    // Right-aligned instruction bits, trimmed to the shorter of length and capture width
    function automatic logic [XW-1:0] insn_trim(input logic [XW-1:0] bits, input logic [7:0] len);
        logic [XW-1:0] m;
        m = '0;
        for (int i = 0; i < XW; i++) begin
            if (i < CAP_W && i < int'(len)) begin
                m[i] = 1'b1;
            end
        end
        insn_trim = bits & m;
    endfunction

    // ---------------------------------------------------------------
    // Exception priority
    // ---------------------------------------------------------------
    assign sel.exc_req = EXC_REQ_IN;
    assign sel.cust_code = CUST_CODE_IN;
    assign sel.ecall_priv = priv_t'(ECALL_PRIV_IN);

    trap_prio_sel u_sel (
        .sel(sel)
    );

    // ---------------------------------------------------------------
    // Trap capture
    // ---------------------------------------------------------------
    logic trap_ok;
    logic [XW-1:0] cause_nxt;
    logic [XW-1:0] value_nxt;

    // with instruction capture on, an illegal trap waits until the instruction bits are complete
    assign TRAP_STALL_OUT = TRAP_IN && !TRAP_IRQ_IN && sel.any && sel.src == VAL_INSN &&
        ctrl_r[CTRL_INSN_BIT] && !INSN_FULL_IN;
    assign trap_ok = TRAP_IN && !TRAP_STALL_OUT && (TRAP_IRQ_IN || sel.any);

    always_comb begin
        cause_nxt = '0;
        value_nxt = '0;
        if (TRAP_IRQ_IN) begin
            // flag in the top bit, interrupt code below
            cause_nxt[CAUSE_FLAG_BIT] = 1'b1;
            cause_nxt[CODE_W-1:0] = IRQ_CODE_IN;
        end else begin
            cause_nxt[CODE_W-1:0] = sel.code;
            unique case (sel.src)
                // pipeline supplies the virtual portion address
                VAL_ADDR: value_nxt = sel.data_side ? DATA_ADDR_IN : FETCH_ADDR_IN;
                // trimmed bits or zero when capture is off
                VAL_INSN: value_nxt = ctrl_r[CTRL_INSN_BIT] ? insn_trim(INSN_BITS_IN, INSN_LEN_IN) : '0;
                VAL_ZERO: value_nxt = '0;
            endcase
        end
    end

    logic wr_cause;
    logic wr_value;
    logic wr_epc;
    logic wr_ctrl;
    logic [XW-1:0] cause_wd;
    assign wr_cause = ack_r && AVS_WRITE_IN && AVS_ADDRESS_IN == OFF_CAUSE;
    assign wr_value = ack_r && AVS_WRITE_IN && AVS_ADDRESS_IN == OFF_VALUE;
    assign wr_epc = ack_r && AVS_WRITE_IN && AVS_ADDRESS_IN == OFF_EPC;
    assign wr_ctrl = ack_r && AVS_WRITE_IN && AVS_ADDRESS_IN == OFF_CTRL;
    assign cause_wd = merge_be(cause_r, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);

    // trap beats software; unsupported codes written by software are not kept
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            cause_r <= CAUSE_RST;
        end else if (trap_ok) begin
            cause_r <= cause_nxt;
        end else if (wr_cause) begin
            if (cause_wd[CAUSE_FLAG_BIT] ? irq_ok(cause_wd[CODE_W-1:0]) : exc_ok(cause_wd[CODE_W-1:0])) begin
                cause_r <= {cause_wd[CAUSE_FLAG_BIT], {(XW-1-CODE_W){1'b0}}, cause_wd[CODE_W-1:0]};
            end
        end
    end

    // value register holds any address, written by traps or software
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            value_r <= VALUE_RST;
        end else if (trap_ok) begin
            value_r <= value_nxt;
        end else if (wr_value) begin
            value_r <= merge_be(value_r, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
        end
    end

    // start address of the trapping instruction, low bit always zero
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            epc_r <= EPC_RST;
        end else if (trap_ok) begin
            epc_r <= {TRAP_PC_IN[XW-1:1], 1'b0};
        end else if (wr_epc) begin
            epc_r <= merge_be(epc_r, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN) & ~32'h0000_0001;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_ctrl && AVS_BYTEENABLE_IN[0]) begin
            ctrl_r <= AVS_WRITEDATA_IN[CTRL_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            done_r <= 1'b0;
        end else begin
            done_r <= trap_ok;
        end
    end

    // ---------------------------------------------------------------
    // Avalon slave: one wait cycle per access keeps decode registered
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_r;
        end
    end

    // Read data is taken at the first edge; a trap in the wait cycle shows on the next read
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            rdata_r <= '0;
        end else if (AVS_READ_IN && !ack_r) begin
            unique case (AVS_ADDRESS_IN)
                OFF_CAUSE: rdata_r <= cause_r;
                OFF_VALUE: rdata_r <= value_r;
                OFF_EPC: rdata_r <= epc_r;
                OFF_CTRL: rdata_r <= {{(XW-CTRL_W){1'b0}}, ctrl_r};
                default: rdata_r <= UNMAPPED_RDATA;
            endcase
        end
    end

    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_r;
    assign AVS_READDATA_OUT = rdata_r;
    assign CAUSE_OUT = cause_r;
    assign VALUE_OUT = value_r;
    assign EPC_OUT = epc_r;
    assign TRAP_DONE_OUT = done_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_cause_trap_only: assert property (
        !$past(trap_ok) && !$past(wr_cause) |-> $stable(cause_r))
        else $error("cause changed without trap or write");

    a_unsup_dropped: assert property (wr_cause && !trap_ok &&
        !(cause_wd[CAUSE_FLAG_BIT] ? irq_ok(cause_wd[CODE_W-1:0]) : exc_ok(cause_wd[CODE_W-1:0])) |=> $stable(cause_r))
        else $error("unsupported cause code kept");

    a_flag_irq: assert property (
        trap_ok |=> cause_r[CAUSE_FLAG_BIT] == $past(TRAP_IRQ_IN))
        else $error("interrupt flag wrong after trap");

    a_flag_top: assert property (
        cause_r[XW-2:CODE_W] == '0)
        else $error("cause bits between flag and code not zero");

    a_irq_code: assert property (
        trap_ok && TRAP_IRQ_IN |=> cause_r[CODE_W-1:0] == $past(IRQ_CODE_IN))
        else $error("interrupt code not recorded");

    a_ecall_code: assert property (trap_ok && !TRAP_IRQ_IN && EXC_REQ_IN[X_ECALL] &&
        EXC_REQ_IN[NEXC-1:X_ECALL+1] == '0 |=> cause_r[CODE_W-1:0] ==
        ($past(ECALL_PRIV_IN) == 2'h0 ? EXC_ECALL_U : $past(ECALL_PRIV_IN) == 2'h1 ? EXC_ECALL_S : EXC_ECALL_M))
        else $error("environment call code wrong");

    a_code_legal: assert property (
        trap_ok && !TRAP_IRQ_IN |=> exc_ok(cause_r[CODE_W-1:0]))
        else $error("reserved exception code produced");

    a_illegal_over_misal: assert property (trap_ok && !TRAP_IRQ_IN && EXC_REQ_IN[X_ILLEGAL] &&
        !(|EXC_REQ_IN[NEXC-1:X_ILLEGAL+1]) |=> cause_r[CODE_W-1:0] == EXC_ILLEGAL)
        else $error("illegal instruction lost priority");

    a_break_code: assert property (trap_ok && !TRAP_IRQ_IN && EXC_REQ_IN[X_FETCH_BRK]
        |=> cause_r == {{(XW-CODE_W){1'b0}}, EXC_BREAK})
        else $error("fetch breakpoint not reported as code 3");

    a_value_trap_only: assert property (
        !$past(trap_ok) && !$past(wr_value) |-> $stable(value_r))
        else $error("value changed without trap or write");

    a_value_addr: assert property (trap_ok && !TRAP_IRQ_IN && sel.src == VAL_ADDR && sel.data_side
        |=> value_r == $past(DATA_ADDR_IN))
        else $error("data fault address not captured");

    a_value_zero_irq: assert property (
        trap_ok && TRAP_IRQ_IN |=> value_r == '0)
        else $error("value not cleared on interrupt");

    a_value_fetch: assert property (trap_ok && !TRAP_IRQ_IN && sel.src == VAL_ADDR && !sel.data_side
        |=> value_r == $past(FETCH_ADDR_IN))
        else $error("fetch fault address not captured");

    a_insn_off_zero: assert property (trap_ok && !TRAP_IRQ_IN && sel.src == VAL_INSN &&
        !ctrl_r[CTRL_INSN_BIT] |=> value_r == '0)
        else $error("value not zero with capture off");

    a_insn_upper_zero: assert property (
        trap_ok && !TRAP_IRQ_IN && sel.src == VAL_INSN |=> (value_r >> $past(INSN_LEN_IN)) == '0)
        else $error("instruction bits not right aligned");

    a_insn_full: assert property (trap_ok && !TRAP_IRQ_IN && sel.src == VAL_INSN &&
        ctrl_r[CTRL_INSN_BIT] |-> INSN_FULL_IN)
        else $error("instruction captured before it was complete");

    a_epc_pc: assert property (
        trap_ok |=> epc_r == {$past(TRAP_PC_IN[XW-1:1]), 1'b0})
        else $error("exception pc not recorded");

    a_done_pulse: assert property (
        trap_ok |=> TRAP_DONE_OUT)
        else $error("done pulse missing after trap");

    a_bus_answer: assert property (
        AVS_READ_IN && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
        else $error("bus answer later than one wait cycle");

    a_bus_idle: assert property (
        !AVS_READ_IN && !AVS_WRITE_IN |-> !AVS_WAITREQUEST_OUT)
        else $error("wait request raised with no access");

    // ---------------------------------------------------------------
    // Coverage of the main scenarios
    // ---------------------------------------------------------------
    c_irq_trap: cover property (trap_ok && TRAP_IRQ_IN);
    c_illegal_trap: cover property (trap_ok && sel.src == VAL_INSN && !TRAP_IRQ_IN);
    c_addr_trap: cover property (trap_ok && sel.src == VAL_ADDR && !TRAP_IRQ_IN);
    c_stall: cover property (TRAP_STALL_OUT);
    c_sw_write: cover property (wr_cause);
endmodule
`default_nettype wire

// file: bench/trap_pipe_model.sv
// Hart pipeline model: raises trap reports, may deliver instruction bits late
`timescale 1ns/1ns
`default_nettype none
module trap_pipe_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic send_in,
    input wire logic [3:0] slow_in,
    input wire logic stall_in,
    output logic trap_out,
    output logic full_out
);
    logic [3:0] wait_r;
    // Report stays up while the recorder stalls it
    always_ff @(posedge clk_in) begin
        if (rst_in || send_in) trap_out <= send_in && !rst_in;
        else if (!stall_in) trap_out <= 1'b0;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in || send_in) wait_r <= rst_in ? 4'h0 : slow_in;
        else if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    end
    assign full_out = (wait_r == 4'h0);
endmodule
`default_nettype wire

// file: bench/trap_cause_value_recorder_test.sv
// Self-checking testbench for the trap cause and value recorder
`timescale 1ns/1ns
`default_nettype none
module trap_cause_value_recorder_test;
    import trap_rec_pkg::*;
    logic clk = 1'b0, rst = 1'b1, send = 1'b0, irq = 1'b0, rd = 1'b0, wr = 1'b0, cap = 1'b1;
    logic trap, full, wreq, stall, done;
    logic [5:0] icode = '0, cc = '0;
    logic [14:0] req = '0;
    logic [1:0] pv = '0;
    logic [7:0] len = '0;
    logic [3:0] adr = '0, slow = '0;
    logic [31:0] pc = '0, fa = '0, da = '0, ib = '0, wd = '0, q, rdata, cause, value, epc;
    logic [63:0] w;
    int n_fail = 0, compares = 0, cyc = 0;
    localparam logic [5:0] CODES [15] = '{6'h0,6'h5,6'h7,6'hd,6'hf,6'h4,6'h6,6'h3,6'h3,6'h0,6'h0,6'h2,6'h1,6'hc,6'h3};
    // Two bits per request: 0 zero, 1 fetch address, 2 data address, 3 instruction bits
    localparam logic [29:0] SRCS = 30'h15d0aaa8;
    localparam logic [5:0] IRQS [9] = '{6'h0,6'h1,6'h3,6'h4,6'h5,6'h7,6'h8,6'h9,6'hb};
    localparam logic [3:0] RA [5] = '{OFF_CAUSE, OFF_VALUE, OFF_EPC, OFF_CTRL, 4'h1};
    localparam logic [31:0] RV [5] = '{CAUSE_RST, VALUE_RST, EPC_RST, 32'(CTRL_RST), UNMAPPED_RDATA};
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            end_sim();
        end
    end
    trap_cause_value_recorder u_dut (.REF_CLK_IN(clk), .RST_IN(rst), .TRAP_IN(trap), .TRAP_IRQ_IN(irq),
        .IRQ_CODE_IN(icode), .EXC_REQ_IN(req), .CUST_CODE_IN(cc), .ECALL_PRIV_IN(pv), .TRAP_PC_IN(pc),
        .FETCH_ADDR_IN(fa), .DATA_ADDR_IN(da), .INSN_BITS_IN(ib), .INSN_LEN_IN(len), .INSN_FULL_IN(full),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .CAUSE_OUT(cause), .VALUE_OUT(value),
        .EPC_OUT(epc), .TRAP_STALL_OUT(stall), .TRAP_DONE_OUT(done));
    trap_pipe_model u_pipe (.clk_in(clk), .rst_in(rst), .send_in(send), .slow_in(slow), .stall_in(stall),
        .trap_out(trap), .full_out(full));
    // --------
    // Helpers
    // --------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        n_fail += (got !== exp);
        if (got !== exp) $display("BAD %s expected %h seen %h", nm, exp, got);
    endtask
    function automatic logic [63:0] want();
        logic [31:0] m;
        logic [31:0] v;
        logic [1:0] s;
        m = (len >= 8'h20) ? 32'hffff_ffff : ((32'h1 << len) - 32'h1);
        if (irq) return {1'b1, 25'h0, icode, 32'h0};
        for (int i = 14; i > 0; i--) begin
            s = SRCS[2*i +: 2];
            v = s == 2'h1 ? fa : s == 2'h2 ? da : (s == 2'h3 && cap) ? ib & m : 32'h0;
            if (req[i] && i == X_ECALL) return {26'h0, pv == 2'h0 ? 6'h8 : pv == 2'h1 ? 6'h9 : 6'hb, v};
            if (req[i]) return {26'h0, CODES[i], v};
        end
        return {26'h0, cc, 32'h0};
    endfunction
    // Avalon master: request held until waitrequest is sampled low
    task automatic bus(input logic w_en, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {adr, wd, wr, rd} <= {a, d, w_en, !w_en};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        {rd, wr} <= 2'b00;
    endtask
    task automatic pick(input logic [14:0] r);
        {req, fa, da, ib, pc} <= {r, $urandom, $urandom, $urandom, $urandom};
        {pv, len} <= {2'($urandom), $urandom_range(1) ? 8'h10 : 8'h20};
        cc <= 6'h18 | 6'($urandom_range(7)) | ($urandom_range(1) ? 6'h20 : 6'h0);
    endtask
    task automatic trap_run(input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        {slow, send} <= {s, 1'b1};
        @(posedge clk);
        send <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1);
        w = want();
        chk("cycles", n, (!irq && cap && req[X_ILLEGAL] && req[14:12] == '0) ? 32'(s) + 32'h2 : 32'h2);
        chk("cause", cause, w[63:32]);
        chk("value", value, w[31:0]);
        chk("epc", epc, pc & 32'hffff_fffe);
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // --------
    // Tests
    // --------
    initial begin
        void'($urandom(82));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, 4'h1, 32'hffff_ffff);
        foreach (RA[i]) begin
            bus(1'b0, RA[i], '0);
            chk("reset read", q, RV[i]);
        end
        $display("test reset done");
        irq <= 1'b1;
        foreach (IRQS[i]) begin
            icode <= IRQS[i];
            pick(15'($urandom));
            trap_run(4'h0);
        end
        irq <= 1'b0;
        $display("test interrupts done");
        for (int i = 0; i < NEXC; i++) begin
            pick(15'h1 << i);
            trap_run(4'h3);
            bus(1'b0, OFF_CAUSE, '0);
            chk("cause read", q, w[63:32]);
        end
        $display("test single causes done");
        repeat (150) begin
            pick(15'($urandom) | 15'h1);
            trap_run(4'($urandom_range(3)));
        end
        $display("test priority done");
        cap = 1'b0;
        bus(1'b1, OFF_CTRL, '0);
        pick(15'h1 << X_ILLEGAL);
        trap_run(4'h2);
        bus(1'b1, OFF_CAUSE, 32'h8000_0007);
        bus(1'b1, OFF_CAUSE, 32'h8000_0002);
        bus(1'b1, OFF_VALUE, 32'h1234_5678);
        pick('0);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        repeat (4) @(posedge clk);
        chk("cause kept", cause, 32'h8000_0007);
        chk("value kept", value, 32'h1234_5678);
        $display("test software access done");
        end_sim();
    end
endmodule
`default_nettype wire
